// File: rtl/zcdl_regs.svh
// register map, field positions and reset values of the zero-cross block
//
// Notes on behaviour
// - current steering and edge interrupts keep running while the device sleeps.
// - with the disable configuration bit zero the detector is active from reset.
// - with the disable configuration bit one, software enable must be set.
// - disable configuration bit zero keeps detector on regardless of software enable.
// - module power-off disables the detector only when configuration permits it.
// - software enable is bit 7; clear hands the pin to normal controls.
// - level bit 5 reads one while sinking, reversed when polarity set.
// - invert bit 4 inverts the logic output when set.
// - rise enable bit 1 lets low-to-high output transitions set the flag.
// - fall enable bit 0 lets high-to-low output transitions set the flag.
// - control bits 6, 3 and 2 read zero and ignore writes.
// - level bit follows the invert setting even while the detector is off.
// - toggling invert may make an edge and raise the flag, enabled or not.
// - an enabled edge during the flag clear leaves the flag set.
`ifndef ZCDL_REGS_SVH
`define ZCDL_REGS_SVH

// ****************************************************************
// byte addresses on the register bus
// ****************************************************************
`define ZCDL_ADDR_W 8
`define ZCDL_OFF_CTRL 8'h00
`define ZCDL_OFF_STATUS 8'h04
`define ZCDL_OFF_MASK 8'h08
`define ZCDL_OFF_CFG 8'h0c

// ****************************************************************
// control register fields
// ****************************************************************
`define ZCDL_CTRL_SW_EN 7
`define ZCDL_CTRL_LEVEL 5
`define ZCDL_CTRL_INVERT 4
`define ZCDL_CTRL_RISE 1
`define ZCDL_CTRL_FALL 0
`define ZCDL_CTRL_WMASK 8'h93
`define ZCDL_CTRL_RST 8'h00

// ****************************************************************
// status, mask and configuration fields
// ****************************************************************
`define ZCDL_STAT_FLAG 0
`define ZCDL_CFG_DISABLE 0
`define ZCDL_CFG_PWR_OFF 1
`define ZCDL_CFG_DIS_RST 1'b0
`define ZCDL_PWR_OFF_RST 1'b0
`define ZCDL_MASK_RST 1'b0

`endif

// File: rtl/zcdl_pkg.sv
// types shared by the zero-cross block
package zcdl_pkg;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } zcdl_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } zcdl_apb_rsp_s;

    typedef enum logic [2:0] {
        REG_CTRL = 3'b000,
        REG_STATUS = 3'b001,
        REG_MASK = 3'b010,
        REG_CFG = 3'b011,
        REG_NONE = 3'b111
    } zcdl_reg_e;

    typedef struct packed {
        logic stage1;
        logic stage2;
    } zcdl_sync_s;

    typedef struct packed {
        logic [7:0] ctrl;
        logic cfg_dis;
        logic pwr_off;
        logic mask;
        logic flag;
        logic level;
        logic active;
        logic pin_rel;
        logic irq;
        logic rd_clr;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } zcdl_state_s;

endpackage

// File: rtl/zcdl_sync.sv
// two-stage synchroniser for the comparator level
`timescale 1ns/10ps
`default_nettype none
module zcdl_sync (
    input wire logic clock_in,  // system clock
    input wire logic rst_in,    // synchronous reset, high
    input wire logic async_in,  // raw level, any timing
    output logic sync_out       // level after two flops
);
    zcdl_pkg::zcdl_sync_s st_reg;
    zcdl_pkg::zcdl_sync_s st_next;

    // stage1 is read only by stage2
    always_comb begin
        st_next = st_reg;
        st_next.stage1 = async_in;
        st_next.stage2 = st_reg.stage1;
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.stage2;
endmodule
`default_nettype wire

// File: rtl/zcdl_top.sv
// zero-cross detector control, edge interrupt and register slave
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "zcdl_regs.svh"
module zcdl_top (
    input wire logic clock_in,                  // system clock, 200 MHz
    input wire logic rst_in,                    // synchronous reset, high
    input wire zcdl_pkg::zcdl_apb_req_s apb_in, // apb request
    output zcdl_pkg::zcdl_apb_rsp_s apb_out,    // apb response
    input wire logic raw_sink_in,               // comparator: 1 = sinking
    output logic detector_active_out,           // analog source/sink enable
    output logic pin_release_out,               // pin under normal controls
    output logic crossing_logic_out,            // logic level to peers
    output logic irq_out                        // level interrupt
);

    // ****************************************************************
    // address decode
    // ****************************************************************
    function automatic zcdl_pkg::zcdl_reg_e reg_sel(
        input logic [7:0] addr
    );
        zcdl_pkg::zcdl_reg_e sel;
        sel = zcdl_pkg::REG_NONE;
        case (addr)
            `ZCDL_OFF_CTRL: begin
                sel = zcdl_pkg::REG_CTRL;
            end
            `ZCDL_OFF_STATUS: begin
                sel = zcdl_pkg::REG_STATUS;
            end
            `ZCDL_OFF_MASK: begin
                sel = zcdl_pkg::REG_MASK;
            end
            `ZCDL_OFF_CFG: begin
                sel = zcdl_pkg::REG_CFG;
            end
            default: begin
                sel = zcdl_pkg::REG_NONE;
            end
        endcase
        return sel;
    endfunction

    // ****************************************************************
    // state and synchroniser
    // ****************************************************************
    zcdl_pkg::zcdl_state_s st_reg;
    zcdl_pkg::zcdl_state_s st_next;
    logic sync_level;
    logic logic_now;
    logic rise_evt;
    logic fall_evt;
    logic set_evt;
    logic setup_ph;
    logic done_ph;
    logic clr_evt;
    zcdl_pkg::zcdl_reg_e sel;

    // raw comparator output is asynchronous to clock_in
    zcdl_sync u_sync (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .async_in(raw_sink_in),
        .sync_out(sync_level)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_next = st_reg;
        sel = reg_sel(apb_in.paddr);
        setup_ph = apb_in.psel & ~apb_in.penable;
        done_ph = apb_in.psel & apb_in.penable & st_reg.pready;

        // level and edges run whether enabled or not, and in sleep
        logic_now = sync_level ^ st_reg.ctrl[`ZCDL_CTRL_INVERT];
        st_next.level = logic_now;
        rise_evt = logic_now & ~st_reg.level;
        fall_evt = ~logic_now & st_reg.level;
        set_evt = (rise_evt & st_reg.ctrl[`ZCDL_CTRL_RISE])
            | (fall_evt & st_reg.ctrl[`ZCDL_CTRL_FALL]);

        // a read of status clears only what that read returned, so an
        // edge landing between capture and completion is never lost
        clr_evt = done_ph & ~apb_in.pwrite & st_reg.rd_clr;
        st_next.flag = (st_reg.flag & ~clr_evt) | set_evt;

        // response defaults: one access cycle per transfer
        st_next.pready = setup_ph;
        st_next.pslverr = setup_ph & (sel == zcdl_pkg::REG_NONE);
        st_next.rd_clr = 1'b0;

        if (setup_ph && !apb_in.pwrite) begin
            st_next.prdata = 32'h0000_0000;
            case (sel)
                zcdl_pkg::REG_CTRL: begin
                    st_next.prdata[7:0] = st_reg.ctrl;
                    st_next.prdata[`ZCDL_CTRL_LEVEL] = st_reg.level;
                end
                zcdl_pkg::REG_STATUS: begin
                    st_next.prdata[`ZCDL_STAT_FLAG] = st_reg.flag;
                    st_next.rd_clr = st_reg.flag;
                end
                zcdl_pkg::REG_MASK: begin
                    st_next.prdata[`ZCDL_STAT_FLAG] = st_reg.mask;
                end
                zcdl_pkg::REG_CFG: begin
                    st_next.prdata[`ZCDL_CFG_DISABLE] = st_reg.cfg_dis;
                    st_next.prdata[`ZCDL_CFG_PWR_OFF] = st_reg.pwr_off;
                end
                default: begin
                    st_next.prdata = 32'h0000_0000;
                end
            endcase
        end

        // writes land at the completing edge, byte lane 0 only
        if (done_ph && apb_in.pwrite && apb_in.pstrb[0]) begin
            case (sel)
                zcdl_pkg::REG_CTRL: begin
                    st_next.ctrl = apb_in.pwdata[7:0]
                        & `ZCDL_CTRL_WMASK;
                end
                zcdl_pkg::REG_MASK: begin
                    st_next.mask = apb_in.pwdata[`ZCDL_STAT_FLAG];
                end
                zcdl_pkg::REG_CFG: begin
                    st_next.cfg_dis = apb_in.pwdata[`ZCDL_CFG_DISABLE];
                    st_next.pwr_off = apb_in.pwdata[`ZCDL_CFG_PWR_OFF];
                end
                default: begin
                    st_next.ctrl = st_reg.ctrl;
                end
            endcase
        end

        // power-off is honoured only where the configuration allows
        // software control; otherwise the detector cannot be stopped
        if (st_next.cfg_dis) begin
            st_next.active = st_next.ctrl[`ZCDL_CTRL_SW_EN]
                & ~st_next.pwr_off;
        end else begin
            st_next.active = 1'b1;
        end
        st_next.pin_rel = ~st_next.active;

        st_next.irq = st_next.flag & st_next.mask;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            st_reg <= '0;
            st_reg.ctrl <= `ZCDL_CTRL_RST;
            st_reg.cfg_dis <= `ZCDL_CFG_DIS_RST;
            st_reg.pwr_off <= `ZCDL_PWR_OFF_RST;
            st_reg.mask <= `ZCDL_MASK_RST;
            st_reg.active <= ~`ZCDL_CFG_DIS_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // outputs, all straight from flops
    // ****************************************************************
    assign apb_out.prdata = st_reg.prdata;
    assign apb_out.pready = st_reg.pready;
    assign apb_out.pslverr = st_reg.pslverr;
    assign detector_active_out = st_reg.active;
    assign pin_release_out = st_reg.pin_rel;
    assign crossing_logic_out = st_reg.level;
    assign irq_out = st_reg.irq;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    sync_delay_a: assert property (
        $stable(st_reg.ctrl[`ZCDL_CTRL_INVERT]) [*4]
        |-> crossing_logic_out == ($past(raw_sink_in, 3)
            ^ st_reg.ctrl[`ZCDL_CTRL_INVERT])
    ) else $error("level does not follow raw input after three cycles");

    invert_flip_a: assert property (
        ($changed(st_reg.ctrl[`ZCDL_CTRL_INVERT]) && $stable(sync_level))
        |=> $changed(crossing_logic_out)
    ) else $error("invert change did not flip the logic level");

    rise_flag_a: assert property (
        (rise_evt && st_reg.ctrl[`ZCDL_CTRL_RISE]) |=> st_reg.flag
    ) else $error("enabled rising edge did not set the flag");

    fall_flag_a: assert property (
        (fall_evt && st_reg.ctrl[`ZCDL_CTRL_FALL]) |=> st_reg.flag
    ) else $error("enabled falling edge did not set the flag");

    rise_quiet_a: assert property (
        (!st_reg.flag && rise_evt && !st_reg.ctrl[`ZCDL_CTRL_RISE])
        |=> !st_reg.flag
    ) else $error("disabled rising edge set the flag");

    clear_race_a: assert property (
        (clr_evt && set_evt) |=> st_reg.flag [*1] ##1 1'b1
    ) else $error("edge during clear was lost");

    always_on_a: assert property (
        !st_reg.cfg_dis |-> detector_active_out
    ) else $error("detector off while configuration forces it on");

    sw_gate_a: assert property (
        (st_reg.cfg_dis && !st_reg.ctrl[`ZCDL_CTRL_SW_EN])
        |-> !detector_active_out && pin_release_out
    ) else $error("detector on without software enable");

    power_off_a: assert property (
        (st_reg.cfg_dis && st_reg.pwr_off) |-> !detector_active_out
    ) else $error("power-off did not stop the detector");

    unimpl_bits_a: assert property (
        (st_reg.ctrl & ~`ZCDL_CTRL_WMASK) == 8'h00
    ) else $error("unimplemented control bits hold a one");

    ready_pulse_a: assert property (
        (apb_in.psel && !apb_in.penable) |=> apb_out.pready ##1 !apb_out.pready
    ) else $error("access phase not answered in one cycle");

    irq_level_a: assert property (
        irq_out == (st_reg.flag && st_reg.mask)
    ) else $error("interrupt does not match the unmasked flag");

    // ****************************************************************
    // bus checks
    // ****************************************************************
    // reads are answered from a snapshot taken at the setup edge
    ready_idle_a: assert property (
        !apb_in.psel |=> !apb_out.pready
    ) else $error("ready raised with no transfer selected");

    slverr_set_a: assert property (
        (done_ph && sel == zcdl_pkg::REG_NONE) |-> apb_out.pslverr
    ) else $error("unmapped access completed without an error");

    slverr_clear_a: assert property (
        (done_ph && sel != zcdl_pkg::REG_NONE) |-> !apb_out.pslverr
    ) else $error("mapped access flagged as an error");

    ctrl_write_a: assert property (
        (done_ph && apb_in.pwrite && apb_in.pstrb[0]
            && sel == zcdl_pkg::REG_CTRL)
        |=> st_reg.ctrl == ($past(apb_in.pwdata[7:0]) & `ZCDL_CTRL_WMASK)
    ) else $error("control write did not land as masked");

    mask_write_a: assert property (
        (done_ph && apb_in.pwrite && apb_in.pstrb[0]
            && sel == zcdl_pkg::REG_MASK)
        |=> st_reg.mask == $past(apb_in.pwdata[`ZCDL_STAT_FLAG])
    ) else $error("mask write did not land");

    cfg_write_a: assert property (
        (done_ph && apb_in.pwrite && apb_in.pstrb[0]
            && sel == zcdl_pkg::REG_CFG)
        |=> st_reg.cfg_dis == $past(apb_in.pwdata[`ZCDL_CFG_DISABLE])
            && st_reg.pwr_off == $past(apb_in.pwdata[`ZCDL_CFG_PWR_OFF])
    ) else $error("configuration write did not land");

    strobe_gate_a: assert property (
        (done_ph && apb_in.pwrite && !apb_in.pstrb[0])
        |=> $stable(st_reg.ctrl) && $stable(st_reg.mask)
            && $stable(st_reg.cfg_dis) && $stable(st_reg.pwr_off)
    ) else $error("write without lane zero changed a register");

    status_ro_a: assert property (
        (done_ph && apb_in.pwrite && sel == zcdl_pkg::REG_STATUS && !set_evt)
        |=> st_reg.flag == $past(st_reg.flag)
    ) else $error("status write changed the flag");

    read_upper_a: assert property (
        (done_ph && !apb_in.pwrite) |-> apb_out.prdata[31:8] == 24'h000000
    ) else $error("read data above the low byte not zero");

    ctrl_holes_a: assert property (
        (done_ph && !apb_in.pwrite && sel == zcdl_pkg::REG_CTRL)
        |-> (apb_out.prdata[7:0] & 8'h4c) == 8'h00
    ) else $error("unimplemented control bits read as one");

    level_read_a: assert property (
        (done_ph && !apb_in.pwrite && sel == zcdl_pkg::REG_CTRL)
        |-> apb_out.prdata[`ZCDL_CTRL_LEVEL] == $past(crossing_logic_out)
    ) else $error("level bit does not match the logic level");

    flag_read_a: assert property (
        (done_ph && !apb_in.pwrite && sel == zcdl_pkg::REG_STATUS)
        |-> apb_out.prdata[`ZCDL_STAT_FLAG] == $past(st_reg.flag)
    ) else $error("status read does not return the flag");

    mask_read_a: assert property (
        (done_ph && !apb_in.pwrite && sel == zcdl_pkg::REG_MASK)
        |-> apb_out.prdata[`ZCDL_STAT_FLAG] == $past(st_reg.mask)
    ) else $error("mask read does not return the mask");

    // ****************************************************************
    // event and enable checks
    // ****************************************************************
    // the flag is sticky: only a status read may take it down
    fall_quiet_a: assert property (
        (!st_reg.flag && fall_evt && !st_reg.ctrl[`ZCDL_CTRL_FALL])
        |=> !st_reg.flag
    ) else $error("disabled falling edge set the flag");

    status_clear_a: assert property (
        (clr_evt && !set_evt) |=> !st_reg.flag
    ) else $error("status read did not clear the flag");

    flag_hold_a: assert property (
        (st_reg.flag && !clr_evt) |=> st_reg.flag
    ) else $error("flag dropped without a status read");

    no_cause_a: assert property (
        (!st_reg.flag && !set_evt) |=> !st_reg.flag
    ) else $error("flag set without an enabled edge");

    sw_enable_a: assert property (
        (st_reg.cfg_dis && st_reg.ctrl[`ZCDL_CTRL_SW_EN] && !st_reg.pwr_off)
        |-> detector_active_out && !pin_release_out
    ) else $error("software enable did not start the detector");

    pin_release_a: assert property (
        pin_release_out == !detector_active_out
    ) else $error("pin release disagrees with detector state");

    off_edge_a: assert property (
        (!detector_active_out && set_evt) |=> st_reg.flag
    ) else $error("edge while detector off did not set the flag");

endmodule
`default_nettype wire

// File: testbench/zcdl_wave_model.sv
// model of the ac waveform as seen at the comparator sink level
`timescale 1ns/10ps
`default_nettype none
module zcdl_wave_model (
    input wire logic level_in, // commanded sink level
    output var logic sink_out  // comparator level, off the clock grid
);
    // the comparator switches with no regard to the system clock
    initial sink_out = 1'b0;
    always @(level_in) sink_out <= #1.3 level_in;
endmodule
`default_nettype wire

// File: testbench/zero_cross_detect_logic_bench.sv
// self-checking bench for the zero-cross detector block
`timescale 1ns/10ps
`default_nettype none
`include "zcdl_regs.svh"
module zero_cross_detect_logic_bench;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    zcdl_pkg::zcdl_apb_req_s req = '0;
    zcdl_pkg::zcdl_apb_rsp_s rsp;
    logic wave_level = 1'b0;
    logic raw_sink;
    logic active;
    logic release_pin;
    logic logic_lvl;
    logic irq;
    logic [31:0] rdat;
    logic rerr;
    logic [3:0] strb = 4'hf;
    int n_errors = 0;
    int tests_run = 0;

    always #2.5 clock_in = ~clock_in;

    zcdl_top dut_u (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .apb_in(req),
        .apb_out(rsp),
        .raw_sink_in(raw_sink),
        .detector_active_out(active),
        .pin_release_out(release_pin),
        .crossing_logic_out(logic_lvl),
        .irq_out(irq)
    );

    zcdl_wave_model wave_u (
        .level_in(wave_level),
        .sink_out(raw_sink)
    );

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task stop_test;
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clock_in);
        req <= '{1'b1, 1'b0, wr, a, d, strb};
        @(posedge clock_in);
        req.penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clock_in);
            if (rsp.pready === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            $display("Error at %0t: no pready", $time);
            stop_test();
        end else begin
            rdat = rsp.prdata;
            rerr = rsp.pslverr;
            req <= '0;
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    // two sync flops plus the level register, with margin for the skew
    task wave(input logic v);
        @(posedge clock_in);
        wave_level <= v;
        cyc(6);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task t_reset;
        rd(`ZCDL_OFF_CTRL);
        chk(rdat, 32'h0, "ctrl reset");
        rd(`ZCDL_OFF_STATUS);
        chk(rdat, 32'h0, "status reset");
        rd(`ZCDL_OFF_MASK);
        chk(rdat, 32'h0, "mask reset");
        rd(`ZCDL_OFF_CFG);
        chk(rdat, 32'h0, "cfg reset");
        chk(active, 1'b1, "active at reset");
        chk(release_pin, 1'b0, "pin held at reset");
        $display("test reset done");
    endtask

    task t_enable;
        wr(`ZCDL_OFF_CFG, 8'h02);
        cyc(2);
        chk(active, 1'b1, "power-off ignored");
        wr(`ZCDL_OFF_CFG, 8'h01);
        cyc(2);
        chk(active, 1'b0, "off without sw enable");
        chk(release_pin, 1'b1, "pin released");
        wr(`ZCDL_OFF_CTRL, 8'h80);
        cyc(2);
        chk(active, 1'b1, "sw enable");
        wr(`ZCDL_OFF_CFG, 8'h03);
        cyc(2);
        chk(active, 1'b0, "power-off honoured");
        wr(`ZCDL_OFF_CFG, 8'h00);
        wr(`ZCDL_OFF_CTRL, 8'h00);
        cyc(2);
        chk(active, 1'b1, "always on");
        $display("test enable done");
    endtask

    task t_level;
        wr(`ZCDL_OFF_CFG, 8'h01);
        wave(1'b1);
        chk(logic_lvl, 1'b1, "sink level");
        rd(`ZCDL_OFF_CTRL);
        chk(rdat, 32'h20, "level bit sink");
        wr(`ZCDL_OFF_CTRL, 8'h10);
        cyc(2);
        chk(logic_lvl, 1'b0, "inverted");
        rd(`ZCDL_OFF_CTRL);
        chk(rdat, 32'h10, "level bit while off");
        wr(`ZCDL_OFF_CTRL, 8'h00);
        wave(1'b0);
        rd(`ZCDL_OFF_CTRL);
        chk(rdat, 32'h0, "level bit source");
        rd(`ZCDL_OFF_STATUS);
        chk(rdat, 32'h0, "no enables no flag");
        wr(`ZCDL_OFF_CFG, 8'h00);
        $display("test level done");
    endtask

    task t_edges;
        wr(`ZCDL_OFF_MASK, 8'h01);
        wr(`ZCDL_OFF_CTRL, 8'h02);
        wave(1'b1);
        chk(irq, 1'b1, "rise irq");
        rd(`ZCDL_OFF_STATUS);
        chk(rdat, 32'h1, "rise flag");
        rd(`ZCDL_OFF_STATUS);
        chk(rdat, 32'h0, "read clears");
        wave(1'b0);
        chk(irq, 1'b0, "fall ignored");
        wr(`ZCDL_OFF_CTRL, 8'h01);
        wave(1'b1);
        chk(irq, 1'b0, "rise ignored");
        wave(1'b0);
        chk(irq, 1'b1, "fall irq");
        rd(`ZCDL_OFF_STATUS);
        chk(rdat, 32'h1, "fall flag");
        cyc(2);
        chk(irq, 1'b0, "irq drops");
        $display("test edges done");
    endtask

    task t_invert;
        wr(`ZCDL_OFF_CTRL, 8'h12);
        cyc(2);
        chk(irq, 1'b1, "invert edge irq");
        rd(`ZCDL_OFF_STATUS);
        chk(rdat, 32'h1, "invert flag");
        wr(`ZCDL_OFF_MASK, 8'h00);
        wr(`ZCDL_OFF_CTRL, 8'h03);
        cyc(2);
        chk(irq, 1'b0, "masked");
        rd(`ZCDL_OFF_STATUS);
        chk(rdat, 32'h1, "masked flag set");
        wr(`ZCDL_OFF_MASK, 8'h01);
        $display("test invert done");
    endtask

    task t_race;
        wave(1'b1);
        // the new edge lands on the access edge of the clearing read
        @(posedge clock_in);
        wave_level <= 1'b0;
        rd(`ZCDL_OFF_STATUS);
        cyc(4);
        chk(irq, 1'b1, "set wins");
        rd(`ZCDL_OFF_STATUS);
        chk(rdat, 32'h1, "flag kept");
        $display("test race done");
    endtask

    task t_bits;
        wr(`ZCDL_OFF_CTRL, 8'hff);
        cyc(2);
        rd(`ZCDL_OFF_CTRL);
        chk(rdat, 32'hb3, "unimplemented bits");
        wr(`ZCDL_OFF_STATUS, 8'h00);
        rd(`ZCDL_OFF_STATUS);
        chk(rdat, 32'h1, "status write ignored");
        rd(8'h10);
        chk({31'h0, rerr}, 32'h1, "unmapped error");
        chk(rdat, 32'h0, "unmapped data");
        strb = 4'h0;
        wr(`ZCDL_OFF_CTRL, 8'h00);
        strb = 4'hf;
        rd(`ZCDL_OFF_CTRL);
        chk(rdat, 32'hb3, "lane zero off ignored");
        // clearing software enable stops the detector, yet the invert
        // change still makes a falling edge that sets the flag
        wr(`ZCDL_OFF_CFG, 8'h01);
        wr(`ZCDL_OFF_CTRL, 8'h03);
        cyc(2);
        chk(active, 1'b0, "sw enable cleared");
        rd(`ZCDL_OFF_STATUS);
        chk(rdat, 32'h1, "edge while off");
        @(posedge clock_in);
        rst_in <= 1'b1;
        cyc(5);
        rst_in <= 1'b0;
        rd(`ZCDL_OFF_CTRL);
        chk(rdat, 32'h0, "ctrl after reset");
        chk(active, 1'b1, "active after reset");
        chk(release_pin, 1'b0, "pin held after reset");
        $display("test bits done");
    endtask

    initial begin
        cyc(5);
        rst_in <= 1'b0;
        t_reset();
        t_enable();
        t_level();
        t_edges();
        t_invert();
        t_race();
        t_bits();
        stop_test();
    end
endmodule
`default_nettype wire
